// [acs_pkg.sv]
package acs_pkg;
  // Register word offsets (byte addresses)
  localparam logic [3:0] OFS_CTRL_A = 4'h0;
  localparam logic [3:0] OFS_CTRL_B = 4'h4;
  localparam logic [3:0] OFS_SELECT = 4'h8;
  localparam logic [3:0] OFS_RES_LO = 4'hC;
  // Byte address 0x10 holds the high result byte
  localparam logic [4:0] OFS_RES_HI = 5'h10;
  // Control A field positions
  localparam int CA_DIV_LSB = 0;
  localparam int CA_DONE = 4;
  localparam int CA_ATE = 5;
  localparam int CA_START = 6;
  localparam int CA_EN = 7;
  // Select field positions
  localparam int SEL_CH_LSB = 0;
  localparam int SEL_REF_LSB = 6;
  // Reset values
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] SELECT_RST = 8'h00;
  // Conversion timing in converter clocks (sample points in half-clock units)
  localparam logic [5:0] NORM_LEN = 6'h0D;
  localparam logic [5:0] FIRST_LEN = 6'h19;
  localparam logic [5:0] AUTO_LEN = 6'h10;
  localparam logic [5:0] NORM_SAMPLE_X2 = 6'h07;
  localparam logic [5:0] FIRST_SAMPLE_X2 = 6'h1B;
  localparam logic [5:0] AUTO_SAMPLE_X2 = 6'h04;
  localparam logic [5:0] TRACK_TAIL = 6'h08;
  localparam logic [2:0] TRIG_FREE = 3'h0;
  localparam int SYNC_CYCLES = 3;

  typedef enum logic [2:0] {
    ACS_IDLE = 3'b001,
    ACS_ARM = 3'b010,
    ACS_CONV = 3'b100
  } acs_state_t;

  typedef struct packed {
    logic [1:0] refSel;
    logic [4:0] chanSel;
  } acs_sel_t;
endpackage

// [acs_divider.sv]
module acs_divider (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic [2:0] divSel,
  output logic tick,
  output logic halfTick
);
  import acs_pkg::*;
  logic [6:0] cnt_reg;
  logic [6:0] top;
  logic [6:0] half;

  // ----------------------------------------
  // Divide ratio 2..128
  // ----------------------------------------
  always_comb begin
    top = 7'(({7'h00, 1'b1} << ((divSel == 3'h0) ? 3'h1 : divSel)) - 8'h01);
    half = top >> 1;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 7'h00;
    end else if (clr || cnt_reg >= top) begin
      cnt_reg <= 7'h00;
    end else begin
      cnt_reg <= cnt_reg + 7'h01;
    end
  end

  assign tick = !clr && (cnt_reg >= top);
  assign halfTick = !clr && (cnt_reg == half);
endmodule // acs_divider

// [acs_sequencer.sv]
// Behaviour
// - Start bit write begins one conversion; hardware clears the bit.
// - Channel changed mid-conversion applies after that conversion.
// - Auto trigger rising edge resets prescaler and starts a conversion.
// - Held trigger at completion or edges while converting are ignored.
// - Flag trigger sets despite masking; software clears it to re-arm.
// - Own done flag as trigger gives free running, cleared or not.
// - Start bit works under auto trigger and reads one while converting.
// - Prescaler runs while enable set, held in reset while enable low.
// - Software start begins at next divided converter clock edge.
// - Normal conversion 13 clocks; first after enable 25 clocks.
// - Sample at 3.5 clocks normally, 13.5 for first conversion.
// - On completion write result, set done flag, clear start bit.
// - Auto trigger: sample two clocks after edge, conversion 16 clocks.
// - Free running restarts immediately and keeps start bit set.
// - Selection buffer locks during conversion until last eight clocks.
// - Start at second CPU edge after write; software then waits.
// - Free running: next result old channel, later results new channel.
// - Low byte read blocks result updates until high byte read.
//
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
module acs_sequencer (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] trigIn,
  input wire logic [9:0] convResult,
  output acs_pkg::acs_sel_t activeSel,
  output logic sampleHold,
  output logic convBusy,
  output logic convDone
);
  import acs_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] ctrlA_reg;
  logic [7:0] ctrlB_reg;
  logic [7:0] select_reg;
  logic [9:0] result_reg;
  logic lock_reg;
  logic firstConv_reg;
  logic autoConv_reg;
  logic trigPrev_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [5:0] clkCnt_reg;
  logic [5:0] halfCnt_reg;
  logic [1:0] armDelay_reg;
  acs_sel_t buf_reg;
  acs_state_t state_reg;

  logic busAcc;
  logic wrA;
  logic wrB;
  logic wrSel;
  logic rdLo;
  logic rdHi;
  logic enable;
  logic autoEn;
  logic [2:0] trigSrc;
  logic trigSel;
  logic trigEdge;
  logic startSw;
  logic startAuto;
  logic tick;
  logic halfTick;
  logic prescClr;
  logic [5:0] convLen;
  logic [5:0] sampleAt;
  logic finish;
  logic freeRun;

  assign enable = ctrlA_reg[CA_EN];
  assign autoEn = ctrlA_reg[CA_ATE];
  assign trigSrc = ctrlB_reg[2:0];
  assign freeRun = autoEn && (trigSrc == TRIG_FREE);

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  assign busAcc = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wrA = busAcc && wb_we_i && wb_sel_i[0] && wb_adr_i == 5'(OFS_CTRL_A);
  assign wrB = busAcc && wb_we_i && wb_sel_i[0] && wb_adr_i == 5'(OFS_CTRL_B);
  assign wrSel = busAcc && wb_we_i && wb_sel_i[0] &&
                 wb_adr_i == 5'(OFS_SELECT);
  assign rdLo = busAcc && !wb_we_i && wb_adr_i == 5'(OFS_RES_LO);
  assign rdHi = busAcc && !wb_we_i && wb_adr_i == OFS_RES_HI;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= busAcc;
    end
  end
  assign wb_ack_o = ack_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (busAcc && !wb_we_i) begin
      case (wb_adr_i)
        5'(OFS_CTRL_A): rdata_reg <= {24'h000000, ctrlA_reg};
        5'(OFS_CTRL_B): rdata_reg <= {24'h000000, ctrlB_reg};
        5'(OFS_SELECT): rdata_reg <= {24'h000000, select_reg};
        5'(OFS_RES_LO): rdata_reg <= {24'h000000, result_reg[7:0]};
        OFS_RES_HI: rdata_reg <= {30'h00000000, result_reg[9:8]};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end
  assign wb_dat_o = rdata_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlB_reg <= CTRL_B_RST;
    end else if (wrB) begin
      ctrlB_reg <= {5'h00, wb_dat_i[2:0]};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      select_reg <= SELECT_RST;
    end else if (wrSel) begin
      select_reg <= {wb_dat_i[7:6], 1'b0, wb_dat_i[4:0]};
    end
  end

  // ----------------------------------------
  // Trigger edge detection
  // ----------------------------------------
  assign trigSel = trigIn[trigSrc];
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trigPrev_reg <= 1'b0;
    end else begin
      trigPrev_reg <= trigSel;
    end
  end
  // edge starts conversion; ignored unless idle; flag
  assign trigEdge = trigSel && !trigPrev_reg;
  assign startAuto = enable && autoEn && !freeRun && trigEdge &&
                     state_reg == ACS_IDLE;

  // software start bit; works with auto trigger
  assign startSw = enable && wrA && wb_dat_i[CA_START] &&
                   state_reg == ACS_IDLE;

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  // held in reset while disabled; reset on trigger
  assign prescClr = !enable || startAuto;

  acs_divider u_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clr(prescClr),
    .divSel(ctrlA_reg[CA_DIV_LSB +: 3]),
    .tick(tick),
    .halfTick(halfTick)
  );

  // ----------------------------------------
  // Conversion timing
  // ----------------------------------------
  // normal and first lengths; auto length
  always_comb begin
    if (firstConv_reg) begin
      convLen = FIRST_LEN;
      sampleAt = FIRST_SAMPLE_X2;
    end else if (autoConv_reg) begin
      convLen = AUTO_LEN;
      sampleAt = AUTO_SAMPLE_X2;
    end else begin
      convLen = NORM_LEN;
      sampleAt = NORM_SAMPLE_X2;
    end
  end
  assign finish = state_reg == ACS_CONV && tick &&
                  clkCnt_reg == convLen - 6'h01;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ACS_IDLE;
      armDelay_reg <= 2'h0;
      autoConv_reg <= 1'b0;
    end else if (!enable) begin
      state_reg <= ACS_IDLE;
      armDelay_reg <= 2'h0;
      autoConv_reg <= 1'b0;
    end else begin
      case (state_reg)
        ACS_IDLE: begin
          if (startAuto) begin
            state_reg <= ACS_ARM;
            armDelay_reg <= 2'(SYNC_CYCLES - 1);
            autoConv_reg <= 1'b1;
          end else if (startSw) begin
            state_reg <= ACS_ARM;
            armDelay_reg <= 2'h0;
            autoConv_reg <= 1'b0;
          end
        end
        ACS_ARM: begin
          if (armDelay_reg != 2'h0) begin
            armDelay_reg <= armDelay_reg - 2'h1;
          end else if (autoConv_reg || tick) begin
            state_reg <= ACS_CONV;
          end
        end
        ACS_CONV: begin
          if (finish) begin
            state_reg <= freeRun ? ACS_CONV : ACS_IDLE;
            autoConv_reg <= 1'b0;
          end
        end
        default: state_reg <= ACS_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkCnt_reg <= 6'h00;
      halfCnt_reg <= 6'h00;
    end else if (state_reg != ACS_CONV || finish) begin
      clkCnt_reg <= 6'h00;
      halfCnt_reg <= 6'h00;
    end else begin
      if (tick) begin
        clkCnt_reg <= clkCnt_reg + 6'h01;
      end
      if (tick || halfTick) begin
        halfCnt_reg <= halfCnt_reg + 6'h01;
      end
    end
  end

  assign sampleHold = state_reg == ACS_CONV && (tick || halfTick) &&
                      halfCnt_reg == sampleAt - 6'h01;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      firstConv_reg <= 1'b1;
    end else if (!enable) begin
      firstConv_reg <= 1'b1;
    end else if (finish) begin
      firstConv_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Control A with start and done bits
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlA_reg <= CTRL_A_RST;
    end else begin
      if (wrA) begin
        ctrlA_reg[CA_EN] <= wb_dat_i[CA_EN];
        ctrlA_reg[CA_ATE] <= wb_dat_i[CA_ATE];
        ctrlA_reg[CA_DIV_LSB +: 3] <= wb_dat_i[CA_DIV_LSB +: 3];
        ctrlA_reg[3] <= 1'b0;
      end
      // Done flag: write one clears, completion wins
      if (finish) begin
        ctrlA_reg[CA_DONE] <= 1'b1;
      end else if (wrA && wb_dat_i[CA_DONE]) begin
        ctrlA_reg[CA_DONE] <= 1'b0;
      end
      if (!enable) begin
        ctrlA_reg[CA_START] <= 1'b0;
      end else if (startSw || startAuto) begin
        ctrlA_reg[CA_START] <= 1'b1;
      // cleared at completion; kept in free running
      end else if (finish && !freeRun) begin
        ctrlA_reg[CA_START] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Result with read lock
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_reg <= 1'b0;
    end else if (rdHi) begin
      lock_reg <= 1'b0;
    end else if (rdLo) begin
      lock_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_reg <= 10'h000;
    end else if (finish && !lock_reg) begin
      result_reg <= convResult;
    end
  end

  // ----------------------------------------
  // Selection buffer
  // ----------------------------------------
  // freeze then track tail; old channel kept
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_reg <= '0;
    end else if (state_reg != ACS_CONV ||
                 clkCnt_reg >= convLen - TRACK_TAIL) begin
      buf_reg.chanSel <= select_reg[SEL_CH_LSB +: 5];
      buf_reg.refSel <= select_reg[SEL_REF_LSB +: 2];
    end
  end

  assign activeSel = buf_reg;
  assign convBusy = state_reg == ACS_CONV;
  assign convDone = finish;
endmodule // acs_sequencer

// [acs_sequencer_sva.sv]
// ----------------------------------------
// Sequencer port checks
// ----------------------------------------
module acs_sequencer_sva (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire acs_pkg::acs_sel_t activeSel,
  input wire logic sampleHold,
  input wire logic convBusy,
  input wire logic convDone
);
  import acs_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  logic [7:0] busyCnt;
  logic sawSample;
  // Cycles spent in the current conversion
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) busyCnt <= 8'h00;
    else if (convDone || !convBusy) busyCnt <= 8'h00;
    else if (busyCnt != 8'hFF) busyCnt <= busyCnt + 8'h01;
  end
  // Sample seen in the current conversion
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) sawSample <= 1'b0;
    else if (sampleHold) sawSample <= 1'b1;
    else if (convDone || !convBusy) sawSample <= 1'b0;
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_badRead;
    s_req ##0 (!wb_we_i && !(wb_adr_i inside {5'h00, 5'h04, 5'h08, 5'h0C,
      5'h10}));
  endsequence
  sequence s_convStart;
    $rose(convBusy);
  endsequence
  property p_ackNext; s_req |=> wb_ack_o; endproperty
  a_ackNext: assert property (p_ackNext) else $error("ack missing");
  property p_ackPulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ackPulse: assert property (p_ackPulse) else $error("ack too long");
  property p_badRead; s_badRead |=> wb_dat_o == 32'h0; endproperty
  a_badRead: assert property (p_badRead) else $error("unmapped read");
  property p_doneConv; convDone |-> convBusy; endproperty
  a_doneConv: assert property (p_doneConv) else $error("done idle");
  property p_doneOnce; convDone |=> !convDone; endproperty
  a_doneOnce: assert property (p_doneOnce) else $error("done long");
  property p_doneLen; convDone |-> busyCnt >= 8'h14; endproperty
  a_doneLen: assert property (p_doneLen) else $error("conv short");
  property p_sampled; convDone |-> sawSample; endproperty
  a_sampled: assert property (p_sampled) else $error("no sample");
  property p_sampleIn; sampleHold |-> convBusy ##1 !sampleHold; endproperty
  a_sampleIn: assert property (p_sampleIn) else $error("bad hold");
  property p_selLock; s_convStart |-> ##2 $stable(activeSel) [*6]; endproperty
  a_selLock: assert property (p_selLock) else $error("sel moved");
endmodule // acs_sequencer_sva
bind acs_sequencer acs_sequencer_sva u_sva (.core_clk, .rst_n, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .activeSel,
  .sampleHold, .convBusy, .convDone);

// [acs_trig_model.sv]
// ----------------------------------------
// Trigger flags and analog source
// ----------------------------------------
module acs_trig_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] setReq,
  input wire logic [7:0] clrReq,
  output logic [7:0] trigIn,
  output logic [9:0] convResult
);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) trigIn <= 8'h00;
    else trigIn <= (trigIn | setReq) & ~clrReq;
  end
  // Input value moves every cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) convResult <= 10'h155;
    else convResult <= convResult + 10'h00B;
  end
endmodule // acs_trig_model

// [test_adc_conversion_sequencer.sv]
module test_adc_conversion_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  import acs_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [4:0] wbAdr = 5'h00;
  logic [31:0] wbDatI = 32'h0;
  logic [31:0] wbDatO;
  logic wbAck, sampleHold, convBusy, convDone;
  logic [7:0] setReq = 8'h00;
  logic [7:0] clrReq = 8'h00;
  logic [7:0] trigIn;
  logic [9:0] convResult;
  logic [9:0] lastRes = 10'h000;
  logic busyPrev = 1'b0;
  time busyT = 0;
  time sampT = 0;
  acs_sel_t activeSel;
  int failures = 0;
  int check_count = 0;
  int doneCnt = 0;
  initial forever #25 core_clk = ~core_clk;
  acs_sequencer dut (.core_clk, .rst_n, .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'h1), .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .trigIn, .convResult, .activeSel,
    .sampleHold, .convBusy, .convDone);
  acs_trig_model trig (.core_clk, .rst_n, .setReq, .clrReq, .trigIn,
    .convResult);
  always @(posedge core_clk) if (convDone === 1'b1) begin
    doneCnt <= doneCnt + 1;
    lastRes <= convResult;
  end
  // Conversion start and sample instants
  always @(posedge core_clk) begin
    busyPrev <= convBusy;
    if (convBusy === 1'b1 && busyPrev !== 1'b1) busyT <= $time;
    if (sampleHold === 1'b1) sampT <= $time;
  end
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic xfer(input logic w, input logic [4:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatI <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    q = wbDatO;
    if (n >= 50) failures++;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rdChk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(e, q);
  endtask
  task automatic waitDone;
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (convDone !== 1'b1 && n < 300);
    if (n >= 300) failures++;
  endtask
  task automatic inRange(input time t0, input time t1, input int m);
    int n;
    n = int'((t1 - t0) / 50);
    chk(32'h1, {31'h0, n >= m - 1 && n <= m + 4});
  endtask
  task automatic pulse(input logic [7:0] m, input logic s);
    if (s) setReq <= m;
    else clrReq <= m;
    @(posedge core_clk);
    setReq <= 8'h00;
    clrReq <= 8'h00;
    @(posedge core_clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rdChk(5'h00, {24'h0, CTRL_A_RST});
    rdChk(5'h04, {24'h0, CTRL_B_RST});
    rdChk(5'h08, {24'h0, SELECT_RST});
    wr(5'h14, 32'hFF);
    rdChk(5'h14, 32'h0);
    $display("test regs ended");
  endtask
  task automatic t_single;
    time t0;
    logic [9:0] keep;
    wr(5'h08, 32'h43);
    wr(5'h00, 32'h80);
    wr(5'h00, 32'hC0);
    t0 = $time;
    rdChk(5'h00, 32'hC0);
    waitDone();
    inRange(t0, $time, 2 * FIRST_LEN);
    inRange(busyT, sampT, FIRST_SAMPLE_X2);
    rdChk(5'h00, 32'h90);
    keep = lastRes;
    rdChk(5'h0C, {24'h0, keep[7:0]});
    wr(5'h00, 32'h90);
    rdChk(5'h00, 32'h80);
    wr(5'h00, 32'hC0);
    t0 = $time;
    repeat (2) @(posedge core_clk);
    wr(5'h08, 32'h45);
    chk(32'h23, {25'h0, activeSel});
    waitDone();
    inRange(t0, $time, 2 * NORM_LEN);
    inRange(busyT, sampT, NORM_SAMPLE_X2);
    repeat (2) @(posedge core_clk);
    chk(32'h25, {25'h0, activeSel});
    rdChk(5'h10, {30'h0, keep[9:8]});
    rdChk(5'h0C, {24'h0, keep[7:0]});
    rdChk(5'h10, {30'h0, keep[9:8]});
    $display("test single ended");
  endtask
  task automatic t_auto;
    time t0;
    int c;
    wr(5'h08, 32'h86);
    wr(5'h04, 32'h2);
    wr(5'h00, 32'hB0);
    c = doneCnt;
    pulse(8'h04, 1'b1);
    t0 = $time - 50;
    repeat (10) @(posedge core_clk);
    chk(32'h1, {31'h0, convBusy});
    chk(32'h46, {25'h0, activeSel});
    pulse(8'h04, 1'b0);
    pulse(8'h04, 1'b1);
    waitDone();
    inRange(t0, $time, 2 * AUTO_LEN + SYNC_CYCLES);
    inRange(t0, sampT, AUTO_SAMPLE_X2 + SYNC_CYCLES);
    repeat (60) @(posedge core_clk);
    chk(c + 1, doneCnt);
    pulse(8'h04, 1'b0);
    pulse(8'h04, 1'b1);
    repeat (60) @(posedge core_clk);
    chk(c + 2, doneCnt);
    $display("test auto ended");
  endtask
  task automatic t_free;
    int c;
    wr(5'h04, 32'h0);
    c = doneCnt;
    wr(5'h00, 32'hF4);
    repeat (940) @(posedge core_clk);
    chk(c + 4, doneCnt);
    rdChk(5'h00, 32'hF4);
    wr(5'h00, 32'h0);
    c = doneCnt;
    repeat (60) @(posedge core_clk);
    chk(c, doneCnt);
    $display("test free ended");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_single();
    t_auto();
    t_free();
    close_out();
  end
  initial begin
    #(50 * 5000);
    failures++;
    $display("watchdog expired");
    close_out();
  end
endmodule // test_adc_conversion_sequencer
